/* File: logic/pmbc_pkg.sv */
// shared constants and types of the power mode and boot controller
package pmbc_pkg;

   localparam int unsigned CLK_PERIOD_NS     = 25;
   localparam int unsigned RESET_HOLD_NS     = 1000;
   localparam int unsigned RESET_HOLD_CYCLES =
      (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RC_START_NS       = 2000;
   localparam int unsigned RC_START_CYCLES   =
      (RC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  RESET_HOLD_LAST   = 8'(RESET_HOLD_CYCLES - 1);
   localparam logic [7:0]  RC_START_LAST     = 8'(RC_START_CYCLES - 1);

   localparam int unsigned EVENT_PIN_LINES = 16;
   localparam int unsigned WAKE_EN_W       = EVENT_PIN_LINES + 2;
   localparam int unsigned IRQ_W           = 4;
   localparam int unsigned BACKUP_WORDS    = 42;
   localparam int unsigned BACKUP_WIDTH    = 16;

   localparam logic [11:0] CTRL_OFFSET        = 12'h000;
   localparam logic [11:0] MODE_STATUS_OFFSET = 12'h004;
   localparam logic [11:0] IRQ_STATUS_OFFSET  = 12'h008;
   localparam logic [11:0] IRQ_CLEAR_OFFSET   = 12'h00C;
   localparam logic [11:0] IRQ_ENABLE_OFFSET  = 12'h010;
   localparam logic [11:0] WAKE_ENABLE_OFFSET = 12'h014;
   localparam logic [11:0] BACKUP_BASE        = 12'h100;
   localparam logic [11:0] BACKUP_END         = 12'h1A8;

   localparam int unsigned CTRL_DEEP_SLEEP_BIT = 0;
   localparam int unsigned CTRL_STANDBY_BIT    = 1;
   localparam int unsigned CTRL_STOP_LP_BIT    = 2;
   localparam int unsigned CTRL_MON_EN_BIT     = 3;
   localparam int unsigned CTRL_MON_FALL_BIT   = 4;
   localparam int unsigned CTRL_MON_RISE_BIT   = 5;
   localparam int unsigned CTRL_CLK_SEL_LSB    = 6;

   localparam int unsigned IRQ_MON_FALL     = 0;
   localparam int unsigned IRQ_MON_RISE     = 1;
   localparam int unsigned IRQ_STOP_WAKE    = 2;
   localparam int unsigned IRQ_STANDBY_EXIT = 3;

   localparam logic [7:0]           CTRL_RESET    = 8'h00;
   localparam logic [WAKE_EN_W-1:0] WAKE_EN_RESET = 18'h00000;
   localparam logic [IRQ_W-1:0]     IRQ_EN_RESET  = 4'h0;
   localparam logic [IRQ_W-1:0]     STANDBY_MASK  = 4'h8;

   typedef enum logic [1:0] {
      BOOT_USER_FLASH, BOOT_SYSTEM_MEMORY, BOOT_EMBEDDED_SRAM
   } pmbc_boot_type;

   typedef enum logic [1:0] {
      REG_MAIN, REG_LOW_POWER, REG_POWER_DOWN
   } pmbc_regulator_type;

   typedef enum logic [1:0] {
      CLKSEL_INTERNAL_FAST_RC, CLKSEL_EXTERNAL_FAST_OSC, CLKSEL_PLL
   } pmbc_sysclk_type;

   typedef enum logic [2:0] {
      ST_RESET, ST_RUN, ST_SLEEP, ST_STOP, ST_STOP_WAKE, ST_STANDBY
   } pmbc_state_type;

   typedef struct packed {
      logic cpu_clk_en;
      logic core_clk_en;
      logic pll_en;
      logic internal_fast_rc_en;
      logic external_fast_oscillator_en;
      logic low_speed_keep;
   } pmbc_clk_ctl_type;

   typedef struct packed {
      logic [EVENT_PIN_LINES-1:0] event_lines;
      logic                       rtc_alarm;
      logic                       wakeup_pin;
      logic                       external_reset_pin_n;
      logic                       watchdog_reset;
   } pmbc_wake_src_type;

   localparam pmbc_clk_ctl_type CLK_RESET = 6'b000101;
   localparam pmbc_clk_ctl_type CLK_RUN   = 6'b110101;
   localparam pmbc_clk_ctl_type CLK_STOP  = 6'b000001;

endpackage

/* File: logic/pmbc_supply_monitor.sv */
// supply threshold monitor: enable gating and crossing events
`timescale 1ns/1ps
module pmbc_supply_monitor (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic enable,
   input  wire logic fall_sel,
   input  wire logic rise_sel,
   input  wire logic above,
   output logic      below_out,
   output logic      fall_evt,
   output logic      rise_evt
);
   typedef struct packed {
      logic active;
      logic level;
      logic fall;
      logic rise;
   } pmbc_mon_state_type;

   pmbc_mon_state_type m_reg;
   pmbc_mon_state_type m_next;

   always_comb begin
      m_next.active = enable;
      m_next.level  = enable & above;
      // first enabled cycle only loads the level, so no false crossing
      m_next.fall   = m_reg.active & enable & fall_sel & m_reg.level & ~above;
      m_next.rise   = m_reg.active & enable & rise_sel & ~m_reg.level & above;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         m_reg <= '0;
      end else begin
         m_reg <= m_next;
      end
   end

   assign below_out = m_reg.active & ~m_reg.level;
   assign fall_evt  = m_reg.fall;
   assign rise_evt  = m_reg.rise;
endmodule

/* File: logic/pmbc_backup_regs.sv */
// backup register array, deliberately without any reset
`timescale 1ns/1ps
module pmbc_backup_regs #(
   parameter int unsigned WORDS = 42,
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             hclk,
   input  wire logic             wr_en,
   input  wire logic [5:0]       wr_idx,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [5:0]       rd_idx,
   output logic      [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [WORDS];

   // no reset term: contents ride through every reset and standby
   always_ff @(posedge hclk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
      rd_data <= mem[rd_idx];
   end
endmodule

/* File: logic/pmbc_top.sv */
// power mode and boot controller: sequencer, registers, wake logic
`timescale 1ns/1ps
// Contract
// - sample boot pins, pick one of three
// - user flash boots bank 1 unless option
// - hold device reset while supply is low
// - monitor interrupt on fall, rise or both
// - monitor idle until software enables it
// - main, low-power, power-down regulator modes
// - regulator on after reset, off in standby
// - sleep halts cpu clock, irq/event resumes
// - stop gates core clocks, pll, fast oscillators
// - stop regulator mode chosen by software
// - stop exits on enabled pin/monitor/alarm line
// - standby powers core and oscillators off
// - standby exits on reset, watchdog, wakeup, alarm
// - low-speed clocks run through stop and standby
// - backup registers survive resets and standby
// - internal fast rc clocks after any reset
module pmbc_top (
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic      [31:0]                 hrdata,
   output logic                             hresp,
   input  wire logic [1:0]                  boot_pins,
   input  wire logic                        flash_bank2_option,
   input  wire logic                        supply_low,
   input  wire logic                        monitor_above,
   input  wire logic                        wfi_req,
   input  wire logic                        wfe_req,
   input  wire logic                        cpu_irq_pending,
   input  wire logic                        cpu_event,
   input  wire pmbc_pkg::pmbc_wake_src_type wake_src,
   output logic                             core_reset_n,
   output logic                             core_power_en,
   output pmbc_pkg::pmbc_clk_ctl_type       clk_ctl,
   output pmbc_pkg::pmbc_regulator_type     regulator_mode,
   output pmbc_pkg::pmbc_sysclk_type        sysclk_sel,
   output pmbc_pkg::pmbc_boot_type          boot_source,
   output logic                             boot_bank2,
   output logic                             irq
);
   import pmbc_pkg::*;

   typedef struct packed {
      pmbc_state_type       state;
      logic [7:0]           cnt;
      logic                 entered_wfe;
      logic                 wakeup_pin_prev;
      logic [7:0]           ctrl;
      logic [WAKE_EN_W-1:0] wake_en;
      logic [IRQ_W-1:0]     irq_stat;
      logic [IRQ_W-1:0]     irq_en;
      logic                 wr_pend;
      logic [11:0]          wr_addr;
      logic                 rd_backup;
      logic [31:0]          rdata;
      logic                 core_reset_n;
      logic                 core_power_en;
      pmbc_clk_ctl_type     clk;
      pmbc_regulator_type   reg_mode;
      pmbc_sysclk_type      sysclk;
      pmbc_boot_type        boot;
      logic                 bank2;
      logic                 irq;
   } pmbc_top_state_type;

   localparam pmbc_top_state_type STATE_RESET = '{
      state:         ST_RESET,
      cnt:           8'h00,
      entered_wfe:   1'b0,
      wakeup_pin_prev:     1'b0,
      ctrl:          CTRL_RESET,
      wake_en:       WAKE_EN_RESET,
      irq_stat:      4'h0,
      irq_en:        IRQ_EN_RESET,
      wr_pend:       1'b0,
      wr_addr:       12'h000,
      rd_backup:     1'b0,
      rdata:         32'h0000_0000,
      core_reset_n:  1'b0,
      core_power_en: 1'b1,
      clk:           CLK_RESET,
      reg_mode:      REG_MAIN,
      sysclk:        CLKSEL_INTERNAL_FAST_RC,
      boot:          BOOT_USER_FLASH,
      bank2:         1'b0,
      irq:           1'b0
   };

   pmbc_top_state_type   s_reg;
   pmbc_top_state_type   s_next;
   logic                 addr_phase;
   logic [11:0]          a_off;
   logic [11:0]          a_rel;
   logic [11:0]          w_rel;
   logic                 in_backup_a;
   logic                 bk_wr_en;
   logic [15:0]          bk_rdata;
   logic [31:0]          rd_word;
   logic                 mon_below;
   logic                 mon_fall;
   logic                 mon_rise;
   logic [WAKE_EN_W-1:0] wake_lines;
   logic                 stop_wake;
   logic                 standby_wake;
   logic                 hard_reset;
   logic                 lose_core;
   logic                 sleep_wake;
   logic [1:0]           clk_field;

   assign addr_phase  = hsel & htrans[1] & hready;
   assign a_off       = haddr[11:0];
   assign a_rel       = a_off - BACKUP_BASE;
   assign w_rel       = s_reg.wr_addr - BACKUP_BASE;
   assign in_backup_a = (a_off >= BACKUP_BASE) && (a_off < BACKUP_END);
   assign bk_wr_en    = s_reg.wr_pend && (s_reg.wr_addr >= BACKUP_BASE)
                        && (s_reg.wr_addr < BACKUP_END);
   assign clk_field   = s_reg.ctrl[CTRL_CLK_SEL_LSB +: 2];

   // any of these takes the whole core domain down
   assign hard_reset   = supply_low
                         | ~wake_src.external_reset_pin_n
                         | wake_src.watchdog_reset;
   assign wake_lines   = {wake_src.rtc_alarm, mon_below, wake_src.event_lines};
   assign stop_wake    = |(wake_lines & s_reg.wake_en);
   assign standby_wake = (wake_src.wakeup_pin & ~s_reg.wakeup_pin_prev)
                         | wake_src.rtc_alarm;
   assign sleep_wake   = cpu_irq_pending | (s_reg.entered_wfe & cpu_event);
   assign lose_core    = hard_reset
                         | ((s_reg.state == ST_STANDBY) & standby_wake);

   pmbc_supply_monitor u_monitor (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .enable    (s_reg.ctrl[CTRL_MON_EN_BIT]),
      .fall_sel  (s_reg.ctrl[CTRL_MON_FALL_BIT]),
      .rise_sel  (s_reg.ctrl[CTRL_MON_RISE_BIT]),
      .above     (monitor_above),
      .below_out (mon_below),
      .fall_evt  (mon_fall),
      .rise_evt  (mon_rise)
   );

   pmbc_backup_regs #(
      .WORDS (BACKUP_WORDS),
      .WIDTH (BACKUP_WIDTH)
   ) u_backup (
      .hclk    (hclk),
      .wr_en   (bk_wr_en),
      .wr_idx  (w_rel[7:2]),
      .wr_data (hwdata[15:0]),
      .rd_idx  (a_rel[7:2]),
      .rd_data (bk_rdata)
   );

   always_comb begin
      rd_word = 32'h0000_0000;
      case (a_off)
         CTRL_OFFSET: begin
            rd_word = {24'h000000, s_reg.ctrl};
         end
         MODE_STATUS_OFFSET: begin
            rd_word = {21'h000000, mon_below, s_reg.sysclk, s_reg.bank2,
                       s_reg.boot, s_reg.reg_mode, s_reg.state};
         end
         IRQ_STATUS_OFFSET: begin
            rd_word = {28'h0000000, s_reg.irq_stat};
         end
         IRQ_ENABLE_OFFSET: begin
            rd_word = {28'h0000000, s_reg.irq_en};
         end
         WAKE_ENABLE_OFFSET: begin
            rd_word = {14'h0000, s_reg.wake_en};
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   always_comb begin
      s_next           = s_reg;
      s_next.wr_pend   = 1'b0;
      s_next.wakeup_pin_prev = wake_src.wakeup_pin;

      if (addr_phase) begin
         s_next.wr_pend   = hwrite;
         s_next.wr_addr   = a_off;
         s_next.rd_backup = ~hwrite & in_backup_a;
         s_next.rdata     = hwrite ? 32'h0000_0000 : rd_word;
      end

      if (s_reg.wr_pend) begin
         case (s_reg.wr_addr)
            CTRL_OFFSET: begin
               s_next.ctrl = hwdata[7:0];
            end
            IRQ_CLEAR_OFFSET: begin
               s_next.irq_stat = s_reg.irq_stat & ~hwdata[IRQ_W-1:0];
            end
            IRQ_ENABLE_OFFSET: begin
               s_next.irq_en = hwdata[IRQ_W-1:0];
            end
            WAKE_ENABLE_OFFSET: begin
               s_next.wake_en = hwdata[WAKE_EN_W-1:0];
            end
            default: begin
               // backup, read-only status or unmapped
            end
         endcase
      end

      // sets follow the clear so a same-cycle event is never lost
      if (mon_fall) begin
         s_next.irq_stat[IRQ_MON_FALL] = 1'b1;
      end
      if (mon_rise) begin
         s_next.irq_stat[IRQ_MON_RISE] = 1'b1;
      end

      case (s_reg.state)
         ST_RESET: begin
            if (s_reg.cnt == RESET_HOLD_LAST) begin
               s_next.state        = ST_RUN;
               s_next.core_reset_n = 1'b1;
               s_next.clk          = CLK_RUN;
               if (!boot_pins[0]) begin
                  s_next.boot = BOOT_USER_FLASH;
               end else if (boot_pins[1]) begin
                  s_next.boot = BOOT_EMBEDDED_SRAM;
               end else begin
                  s_next.boot = BOOT_SYSTEM_MEMORY;
               end
               s_next.bank2 = ~boot_pins[0] & flash_bank2_option;
            end else begin
               s_next.cnt = s_reg.cnt + 8'h01;
            end
         end
         ST_RUN: begin
            s_next.clk = CLK_RUN;
            // reserved select code 3 falls back to the rc oscillator
            if (clk_field == 2'h3) begin
               s_next.sysclk = CLKSEL_INTERNAL_FAST_RC;
            end else begin
               s_next.sysclk = pmbc_sysclk_type'(clk_field);
            end
            s_next.clk.pll_en = (s_next.sysclk == CLKSEL_PLL);
            s_next.clk.external_fast_oscillator_en =
               (s_next.sysclk == CLKSEL_EXTERNAL_FAST_OSC);
            if (wfi_req | wfe_req) begin
               s_next.entered_wfe = wfe_req & ~wfi_req;
               if (!s_reg.ctrl[CTRL_DEEP_SLEEP_BIT]) begin
                  s_next.state          = ST_SLEEP;
                  s_next.clk.cpu_clk_en = 1'b0;
               end else if (s_reg.ctrl[CTRL_STANDBY_BIT]) begin
                  s_next.state         = ST_STANDBY;
                  s_next.core_power_en = 1'b0;
                  s_next.core_reset_n  = 1'b0;
                  s_next.clk           = CLK_STOP;
                  s_next.reg_mode      = REG_POWER_DOWN;
               end else begin
                  s_next.state = ST_STOP;
                  s_next.clk   = CLK_STOP;
                  if (s_reg.ctrl[CTRL_STOP_LP_BIT]) begin
                     s_next.reg_mode = REG_LOW_POWER;
                  end else begin
                     s_next.reg_mode = REG_MAIN;
                  end
               end
            end
         end
         ST_SLEEP: begin
            if (sleep_wake) begin
               s_next.state          = ST_RUN;
               s_next.clk.cpu_clk_en = 1'b1;
            end
         end
         ST_STOP: begin
            if (stop_wake) begin
               s_next.state                   = ST_STOP_WAKE;
               s_next.cnt                     = 8'h00;
               s_next.clk.internal_fast_rc_en = 1'b1;
               s_next.reg_mode                = REG_MAIN;
               s_next.irq_stat[IRQ_STOP_WAKE] = 1'b1;
            end
         end
         ST_STOP_WAKE: begin
            // processor stays halted until the rc has settled
            if (s_reg.cnt == RC_START_LAST) begin
               s_next.state  = ST_RUN;
               s_next.clk    = CLK_RUN;
               s_next.sysclk = CLKSEL_INTERNAL_FAST_RC;
               s_next.ctrl[CTRL_CLK_SEL_LSB +: 2] = 2'h0;
            end else begin
               s_next.cnt = s_reg.cnt + 8'h01;
            end
         end
         ST_STANDBY: begin
            s_next.core_reset_n = 1'b0;
         end
         default: begin
            s_next.state = ST_RESET;
         end
      endcase

      if (lose_core) begin
         s_next.state         = ST_RESET;
         s_next.cnt           = 8'h00;
         s_next.core_reset_n  = 1'b0;
         s_next.core_power_en = 1'b1;
         s_next.clk           = CLK_RESET;
         s_next.reg_mode      = REG_MAIN;
         s_next.sysclk        = CLKSEL_INTERNAL_FAST_RC;
         s_next.ctrl          = CTRL_RESET;
         s_next.wake_en       = WAKE_EN_RESET;
         s_next.irq_en        = IRQ_EN_RESET;
         s_next.entered_wfe   = 1'b0;
         // the standby flag outlives a core reset, not a power loss
         s_next.irq_stat      = s_reg.irq_stat & STANDBY_MASK;
         if (s_reg.state == ST_STANDBY) begin
            s_next.irq_stat[IRQ_STANDBY_EXIT] = 1'b1;
         end
         if (supply_low) begin
            s_next.irq_stat = 4'h0;
         end
      end

      s_next.irq = |(s_next.irq_stat & s_next.irq_en);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg <= STATE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign hrdata         = s_reg.rd_backup ? {16'h0000, bk_rdata} : s_reg.rdata;
   assign core_reset_n   = s_reg.core_reset_n;
   assign core_power_en  = s_reg.core_power_en;
   assign clk_ctl        = s_reg.clk;
   assign regulator_mode = s_reg.reg_mode;
   assign sysclk_sel     = s_reg.sysclk;
   assign boot_source    = s_reg.boot;
   assign boot_bank2     = s_reg.bank2;
   assign irq            = s_reg.irq;
endmodule

/* File: tb/pmbc_top_sva.sv */
// port assertions of the power and boot controller
`timescale 1ns/1ps
module pmbc_top_sva
   import pmbc_pkg::*;
(
   input wire logic                         hclk,
   input wire logic                         hresetn,
   input wire logic                         hreadyout,
   input wire logic                         hresp,
   input wire logic [1:0]                   boot_pins,
   input wire logic                         flash_bank2_option,
   input wire logic                         supply_low,
   input wire logic                         cpu_irq_pending,
   input wire pmbc_pkg::pmbc_wake_src_type  wake_src,
   input wire logic                         core_reset_n,
   input wire logic                         core_power_en,
   input wire pmbc_pkg::pmbc_clk_ctl_type   clk_ctl,
   input wire pmbc_pkg::pmbc_regulator_type regulator_mode,
   input wire pmbc_pkg::pmbc_sysclk_type    sysclk_sel,
   input wire pmbc_pkg::pmbc_boot_type      boot_source,
   input wire logic                         boot_bank2
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not okay");
   chk_supply_reset: assert property (supply_low |-> ##[1:2] !core_reset_n)
      else $error("no reset on low supply");
   chk_standby_off: assert property (!core_power_en |-> !core_reset_n &&
      regulator_mode == REG_POWER_DOWN && clk_ctl == CLK_STOP)
      else $error("bad standby");
   chk_low_speed: assert property (clk_ctl.low_speed_keep)
      else $error("slow clock off");
   chk_stop_clocks: assert property (regulator_mode == REG_LOW_POWER
      |-> clk_ctl == CLK_STOP)
      else $error("clocks on in low power");
   chk_boot_pick: assert property ($rose(core_reset_n) |-> boot_source ==
      (!$past(boot_pins[0]) ? BOOT_USER_FLASH :
       $past(boot_pins[1]) ? BOOT_EMBEDDED_SRAM : BOOT_SYSTEM_MEMORY))
      else $error("wrong boot source");
   chk_boot_bank: assert property ($rose(core_reset_n) |->
      boot_bank2 == ($past(flash_bank2_option) && !$past(boot_pins[0])))
      else $error("wrong flash bank");
   chk_rc_restart: assert property ($rose(clk_ctl.core_clk_en) |->
      sysclk_sel == CLKSEL_INTERNAL_FAST_RC && regulator_mode == REG_MAIN)
      else $error("bad resume clock");
   chk_sleep_resume: assert property (clk_ctl.core_clk_en && !clk_ctl.cpu_clk_en &&
      cpu_irq_pending |-> ##[1:3] clk_ctl.cpu_clk_en)
      else $error("sleep not left");
   chk_standby_wake: assert property (!core_power_en && $rose(wake_src.wakeup_pin)
      |-> ##[1:2] core_power_en)
      else $error("standby not left");
endmodule

bind pmbc_top pmbc_top_sva sva_u (.hclk, .hresetn, .hreadyout, .hresp, .boot_pins,
   .flash_bank2_option, .supply_low, .cpu_irq_pending, .wake_src, .core_reset_n,
   .core_power_en, .clk_ctl, .regulator_mode, .sysclk_sel, .boot_source, .boot_bank2);

/* File: tb/pmbc_top_bench.sv */
// self-checking bench of the power and boot controller
`timescale 1ns/1ps
module pmbc_top_bench;
   import pmbc_pkg::*;
   localparam pmbc_wake_src_type WAKE_IDLE = 20'h00002;
   logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
   logic               flash_bank2_option, supply_low, monitor_above, boot_bank2;
   logic               wfi_req, wfe_req, cpu_irq_pending, cpu_event;
   logic               core_reset_n, core_power_en;
   logic [31:0]        haddr, hwdata, hrdata, d;
   logic [1:0]         htrans, boot_pins;
   logic [2:0]         hsize;
   logic [15:0]        bk[42];
   logic [1:0]         bp[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
   pmbc_wake_src_type  wake_src;
   pmbc_clk_ctl_type   clk_ctl;
   pmbc_regulator_type regulator_mode;
   pmbc_sysclk_type    sysclk_sel;
   pmbc_boot_type      boot_source;
   int                 n_errors, tests_run, idx;

   pmbc_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .boot_pins, .flash_bank2_option,
      .supply_low, .monitor_above, .wfi_req, .wfe_req, .cpu_irq_pending, .cpu_event,
      .wake_src, .core_reset_n, .core_power_en, .clk_ctl, .regulator_mode, .sysclk_sel,
      .boot_source, .boot_bank2, .irq);

   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task automatic close_out;
      $display("%0d errors, %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic tally(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("ERROR at %0t: %s", $time, what);
      end
   endtask

   // address, then data phase, each held until hready
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      int n;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h00000, a};
      hwrite <= w;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge hclk);
            n++;
         end while (hreadyout !== 1'b1 && n < 20);
         if (n >= 20) begin
            tally(1'b0, "bus hang");
            close_out();
         end
         if (p == 0) begin
            htrans <= 2'h0;
            hwdata <= wd;
         end
      end
      q = hrdata;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      logic [31:0] q;
      bus(1'b1, a, wd, q);
   endtask

   task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h00000000, q);
      tally(q === e, "read");
   endtask

   task automatic chk_pin(input logic [7:0] got, input logic [7:0] e);
      tally(got === e, "pin");
   endtask

   task automatic wait_run(input int e);
      int n = 0;
      while (!(core_reset_n === 1'b1 && clk_ctl.cpu_clk_en === 1'b1) && n < 400) begin
         @(posedge hclk);
         n++;
      end
      tally(n >= e - 3 && n <= e + 3, "latency");
      if (n >= 400) close_out();
   endtask

   task automatic sleep_req(input logic wfe);
      if (wfe) wfe_req <= 1'b1;
      else wfi_req <= 1'b1;
      @(posedge hclk);
      wfi_req <= 1'b0;
      wfe_req <= 1'b0;
      repeat (2) @(posedge hclk);
   endtask

   initial begin
      {hresetn, hsel, hwrite, supply_low, wfi_req, wfe_req} = 6'h00;
      {cpu_irq_pending, cpu_event, haddr, hwdata, htrans, boot_pins} = '0;
      {flash_bank2_option, monitor_above, hsize} = 5'h1A;
      wake_src = WAKE_IDLE;
      n_errors = 0;
      tests_run = 0;
      void'($urandom(10213));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      wait_run(41);
      chk_pin(boot_source, BOOT_USER_FLASH);
      chk_pin(boot_bank2, 8'h01);
      chk_pin(sysclk_sel, CLKSEL_INTERNAL_FAST_RC);
      chk_pin(regulator_mode, REG_MAIN);
      for (int k = 0; k < 3; k++) begin
         idx = (k == 0) ? 0 : (k == 1) ? 41 : int'($urandom % 42);
         d = $urandom;
         bk[idx] = d[15:0];
         wr(BACKUP_BASE + 12'(4 * idx), d);
         chk_rd(BACKUP_BASE + 12'(4 * idx), {16'h0000, bk[idx]});
      end
      // crossings ignored when off, then latched but masked
      for (int k = 0; k < 2; k++) begin
         if (k == 1) wr(CTRL_OFFSET, 32'h38);
         repeat (3) @(posedge hclk);
         monitor_above <= 1'b0;
         repeat (3) @(posedge hclk);
         monitor_above <= 1'b1;
         repeat (3) @(posedge hclk);
         chk_rd(IRQ_STATUS_OFFSET, k ? 32'h3 : 32'h0);
      end
      chk_pin(irq, 8'h00);
      wr(IRQ_CLEAR_OFFSET, 32'h3);
      chk_rd(IRQ_STATUS_OFFSET, 32'h0);
      wr(CTRL_OFFSET, 32'h0);
      for (int k = 0; k < 2; k++) begin
         sleep_req(k[0]);
         chk_pin({clk_ctl.cpu_clk_en, clk_ctl.core_clk_en}, 8'h01);
         if (k == 1) cpu_event <= 1'b1;
         else cpu_irq_pending <= 1'b1;
         @(posedge hclk);
         {cpu_event, cpu_irq_pending} <= 2'h0;
         repeat (2) @(posedge hclk);
         chk_pin(clk_ctl, CLK_RUN);
      end
      wr(IRQ_ENABLE_OFFSET, 32'h4);
      wr(WAKE_ENABLE_OFFSET, 32'h20020);
      for (int k = 0; k < 2; k++) begin
         wr(CTRL_OFFSET, k ? 32'h01 : 32'h85);
         sleep_req(1'b1);
         chk_pin(clk_ctl, CLK_STOP);
         chk_pin(regulator_mode, k ? REG_MAIN : REG_LOW_POWER);
         wake_src.event_lines <= 16'h0008;
         repeat (3) @(posedge hclk);
         chk_pin(clk_ctl, CLK_STOP);
         if (k == 1) wake_src <= WAKE_IDLE | 20'h00008;
         else wake_src.event_lines <= 16'h0020;
         @(posedge hclk);
         wake_src <= WAKE_IDLE;
         wait_run(81);
         chk_pin(regulator_mode, REG_MAIN);
         chk_pin(sysclk_sel, CLKSEL_INTERNAL_FAST_RC);
         chk_pin(irq, 8'h01);
         chk_rd(CTRL_OFFSET, k ? 32'h01 : 32'h05);
         wr(IRQ_CLEAR_OFFSET, 32'h4);
         @(posedge hclk);
         chk_pin(irq, 8'h00);
      end
      // each standby exit source, with new boot pins
      for (int k = 0; k < 4; k++) begin
         wr(CTRL_OFFSET, 32'h03);
         boot_pins <= bp[k];
         flash_bank2_option <= 1'($urandom);
         sleep_req(1'b0);
         chk_pin({core_power_en, core_reset_n}, 8'h00);
         chk_pin(regulator_mode, REG_POWER_DOWN);
         case (k)
            0: wake_src.wakeup_pin <= 1'b1;
            1: wake_src.rtc_alarm <= 1'b1;
            2: wake_src.watchdog_reset <= 1'b1;
            default: wake_src.external_reset_pin_n <= 1'b0;
         endcase
         repeat (2) @(posedge hclk);
         wake_src <= WAKE_IDLE;
         wait_run(41);
         chk_pin(boot_source, k == 1 ? BOOT_SYSTEM_MEMORY : k == 2 ? BOOT_EMBEDDED_SRAM
            : BOOT_USER_FLASH);
         chk_rd(IRQ_STATUS_OFFSET, 32'h8);
         chk_rd(CTRL_OFFSET, 32'h0);
         chk_rd(BACKUP_BASE + 12'(4 * idx), {16'h0000, bk[idx]});
         wr(IRQ_CLEAR_OFFSET, 32'h8);
      end
      supply_low <= 1'b1;
      repeat (4) @(posedge hclk);
      chk_pin(core_reset_n, 8'h00);
      supply_low <= 1'b0;
      wait_run(41);
      chk_rd(BACKUP_BASE, {16'h0000, bk[0]});
      chk_rd(12'h020, 32'h0);
      close_out();
   end
endmodule
